// [shared/nmc_pkg.sv]
package nmc_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_STATUS  = 8'h04;
    localparam logic [7:0] OFS_IRQ     = 8'h08;
    localparam logic [7:0] OFS_MASK    = 8'h0c;
    localparam logic [7:0] OFS_SWLAST  = 8'h10;
    localparam logic [7:0] OFS_SWOUT   = 8'h14;
    localparam logic [7:0] OFS_HOSTCFG = 8'h18;
    localparam logic [7:0] OFS_ALIVE   = 8'h1c;

    // CTRL fields
    localparam int CTRL_SCANMODE = 0;
    localparam int CTRL_INEN     = 1;
    localparam int CTRL_AUTOADDR = 2;

    // Interrupt bits
    localparam int IRQ_READY   = 0;
    localparam int IRQ_TIMEOUT = 1;
    localparam int IRQ_RESULT  = 2;
    localparam int IRQ_TRIGGER = 3;

    // Reset values
    localparam logic [31:0] HOSTCFG_RST = 32'h0000_2580;
    localparam logic [31:0] CTRL_RST    = 32'h0000_0004;

    // Frame characters
    localparam logic [7:0] CH_STX  = 8'h02;
    localparam logic [7:0] CH_CR   = 8'h0d;
    localparam logic [7:0] CH_LF   = 8'h0a;
    localparam logic [7:0] CH_S    = 8'h53;
    localparam logic [7:0] CH_T    = 8'h54;
    localparam logic [7:0] CH_PLUS = 8'h2b;
    localparam logic [7:0] CH_ZERO = 8'h30;

    // Timing
    localparam longint CLK_HZ      = 40000000;
    localparam longint INIT_S      = 30;
    localparam longint INIT_CYCLES = INIT_S * CLK_HZ;
    localparam longint SVC_BAUD    = 9600;
    localparam int     SVC_DIV     = int'(CLK_HZ / SVC_BAUD);

    typedef enum logic [2:0] {
        NMC_IDLE  = 3'b000,
        NMC_PROBE = 3'b001,
        NMC_WAIT  = 3'b010,
        NMC_EMIT  = 3'b011,
        NMC_RUN   = 3'b100
    } nmc_state_t;

endpackage : nmc_pkg

// [verilog/nmc_frame_tx.sv]
`timescale 1ns/1ps
`default_nettype none
// Sends STX, two address digits, two payload bytes, CR, LF
module nmc_frame_tx
    import nmc_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] pay0,
    input  wire logic [7:0] pay1,
    input  wire logic       byteRdy,
    output logic            busy,
    output logic            byteVld,
    output logic [7:0]      byteOut
);
    logic [2:0] idx_ff;
    logic       busy_ff;
    logic [7:0] addr_ff;
    logic [7:0] p0_ff;
    logic [7:0] p1_ff;
    logic [3:0] hiNib;
    logic [3:0] loNib;

    assign hiNib = 4'(addr_ff / 8'd10);
    assign loNib = 4'(addr_ff % 8'd10);

    // Byte sequence of one frame
    always_comb begin
        case (idx_ff)
            3'd0:    byteOut = CH_STX;
            3'd1:    byteOut = CH_ZERO + {4'h0, hiNib};
            3'd2:    byteOut = CH_ZERO + {4'h0, loNib};
            3'd3:    byteOut = p0_ff;
            3'd4:    byteOut = p1_ff;
            3'd5:    byteOut = CH_CR;
            default: byteOut = CH_LF;
        endcase
    end
    assign busy    = busy_ff;
    assign byteVld = busy_ff;

    // Advance on each accepted byte
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            idx_ff  <= 3'd0;
            busy_ff <= 1'b0;
            addr_ff <= 8'h00;
            p0_ff   <= 8'h00;
            p1_ff   <= 8'h00;
        end else if (!busy_ff && start) begin
            busy_ff <= 1'b1;
            idx_ff  <= 3'd0;
            addr_ff <= addr;
            p0_ff   <= pay0;
            p1_ff   <= pay1;
        end else if (busy_ff && byteRdy) begin
            idx_ff  <= idx_ff + 3'd1;
            busy_ff <= (idx_ff != 3'd6);
        end
    end
endmodule : nmc_frame_tx
`default_nettype wire

// [verilog/network_master_control.sv]
// Decided for this implementation: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Probe slaves 1..last at each power-up
// - Nonzero rotary wins, else software value
// - Larger rotary value applies at next power-up
// - Report live slave as address plus S
// - 30 s init; silent slave reported address plus T
// - Single-result mode forwards first result only
// - Trigger by host plus character or input
// - Single-result mode unaddressed, off in service
// - Inputs live on scanner variant, else enabled
// - Output functions only on scanner variant
// - Lamp lights while switching output is 1
// - Host port format registers are configurable
// - Auto address handled internally without host
// - Service port fixed format, host suspended
// - Frame is STX, addr hi, lo, payload, CR LF
module network_master_control
    import nmc_pkg::*;
#(
    parameter int     MAX_SLAVES  = 31,
    parameter bit     SCANNER_VAR = 1'b1,
    parameter longint INIT_CYC    = INIT_CYCLES,
    parameter int     PROBE_CYC   = 4000
)(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq,
    input  wire logic [4:0]  rotarySel,
    input  wire logic        serviceSelector,
    input  wire logic [1:0]  switchInPair,
    input  wire logic        slaveAnsVld,
    input  wire logic [7:0]  slaveAnsAddr,
    input  wire logic        slaveAnsIsRead,
    input  wire logic [7:0]  slaveAnsData,
    input  wire logic        hostRxVld,
    input  wire logic [7:0]  hostRxByte,
    input  wire logic        txRdy,
    output logic             netTxVld,
    output logic [7:0]       netTxByte,
    output logic             hostTxVld,
    output logic [7:0]       hostTxByte,
    output logic             svcTxVld,
    output logic [7:0]       svcTxByte,
    output logic [15:0]      baudDiv,
    output logic [1:0]       switchOut,
    output logic [1:0]       lampOut,
    output logic             hostSuspended
);
    // Control and status registers
    nmc_state_t  state_ff;
    nmc_state_t  nxt_state;
    logic [31:0] ctrl_ff;
    logic [31:0] hostCfg_ff;
    logic [31:0] mask_ff;
    logic [31:0] irq_ff;
    logic [31:0] swOut_ff;
    logic [4:0]  swLast_ff;
    logic [4:0]  lastAddr_ff;
    // One bit wider than an address so the search can step past 31
    logic [5:0]  probe_ff;
    logic        lastCaught_ff;
    logic [31:0] alive_ff;
    logic [31:0] tmo_ff;
    logic [31:0] initCnt_ff;
    logic        resultTaken_ff;
    logic        seqOk_ff;
    logic [1:0]  swInPrev_ff;
    // Bus capture and registered outputs
    logic        sel_ff;
    logic        wr_ff;
    logic [7:0]  ofs_ff;
    logic [31:0] hrdata_ff;
    logic        irq_o_ff;
    logic        susp_ff;
    logic [15:0] baud_ff;
    logic [1:0]  swOutQ_ff;
    logic [1:0]  lamp_ff;

    // Bus decode
    wire        acc     = hsel && hready && htrans[1];
    wire        wrData  = sel_ff && wr_ff;
    wire [7:0]  aofs    = haddr[7:0];
    wire [4:0]  effLast = (rotarySel != 5'd0) ? rotarySel : swLast_ff;

    // Mode qualifiers
    wire scanMode = ctrl_ff[CTRL_SCANMODE] && !serviceSelector;
    wire inEnable = SCANNER_VAR ? 1'b1 : ctrl_ff[CTRL_INEN];
    wire swRise   = inEnable && |(switchInPair & ~swInPrev_ff);
    wire hostPlus = hostRxVld && (hostRxByte == CH_PLUS) && !serviceSelector;
    wire trigger  = scanMode && (hostPlus || swRise);
    wire probeTmo = (tmo_ff == 32'(PROBE_CYC));
    wire probeHit = slaveAnsVld && (slaveAnsAddr == {2'b00, probe_ff});
    wire searchEnd = (probe_ff > {1'b0, lastAddr_ff}) || (probe_ff > 6'(MAX_SLAVES));
    wire fwdRead  = slaveAnsVld && slaveAnsIsRead && state_ff == NMC_RUN
                  && (!scanMode || !resultTaken_ff);
    wire initOver = (initCnt_ff >= 32'(INIT_CYC));

    // Frame sender
    logic       txStart, txBusy, txVld;
    logic [7:0] txAddr, txP0, txP1, txByte;
    wire  emitNow = (state_ff == NMC_WAIT) && (probeHit || probeTmo || initOver);
    // A result that arrives while a frame is going out is lost
    assign txStart = (emitNow || fwdRead) && !txBusy;
    // Address of reporting slave; single-result or auto-address mode frames as master 00
    assign txAddr  = fwdRead ? ((scanMode || ctrl_ff[CTRL_AUTOADDR]) ? 8'h00
                                : slaveAnsAddr)
                             : {2'b00, probe_ff};
    assign txP0    = fwdRead ? slaveAnsData : (probeHit ? CH_S : CH_T);
    assign txP1    = fwdRead ? CH_CR : CH_LF;

    nmc_frame_tx u_tx (
        .clk_sys (clk_sys),
        .rst     (rst),
        .start   (txStart),
        .addr    (txAddr),
        .pay0    (txP0),
        .pay1    (txP1),
        .byteRdy (txRdy),
        .busy    (txBusy),
        .byteVld (txVld),
        .byteOut (txByte)
    );

    // Reports go to service or host port; network sees probe traffic
    assign netTxVld   = txVld && (state_ff != NMC_RUN);
    assign netTxByte  = txByte;
    assign hostTxVld  = txVld && !serviceSelector;
    assign hostTxByte = txByte;
    assign svcTxVld   = txVld && serviceSelector;
    assign svcTxByte  = txByte;

    // Power-up search sequencer
    // A last address of zero skips the search and goes straight to run
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            NMC_IDLE:  if (lastCaught_ff) nxt_state = NMC_PROBE;
            NMC_PROBE: nxt_state = searchEnd ? NMC_RUN : NMC_WAIT;
            NMC_WAIT:  if (txStart) nxt_state = NMC_EMIT;
            NMC_EMIT:  if (!txBusy) nxt_state = NMC_PROBE;
            NMC_RUN:   nxt_state = NMC_RUN;
            default:   nxt_state = NMC_IDLE;
        endcase
    end

    // Sequencer state
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) state_ff <= NMC_IDLE;
        else     state_ff <= nxt_state;
    end

    // Catch last address once; a new rotary value counts only at the next power-up
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lastCaught_ff <= 1'b0;
            lastAddr_ff   <= 5'd0;
        end else if (!lastCaught_ff) begin
            lastCaught_ff <= 1'b1;
            lastAddr_ff   <= effLast;
        end
    end

    // Probe address, per-slave timeout and init timer
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            probe_ff   <= 6'd1;
            tmo_ff     <= 32'h0000_0000;
            initCnt_ff <= 32'h0000_0000;
            alive_ff   <= 32'h0000_0000;
        end else begin
            if (state_ff != NMC_RUN && !initOver)
                initCnt_ff <= initCnt_ff + 32'h0000_0001;
            if (state_ff == NMC_WAIT && !probeTmo)
                tmo_ff <= tmo_ff + 32'h0000_0001;
            if (state_ff == NMC_WAIT && txStart) begin
                tmo_ff   <= 32'h0000_0000;
                probe_ff <= probe_ff + 6'd1;
                if (probeHit)
                    alive_ff[probe_ff[4:0]] <= 1'b1;
            end
        end
    end

    // Single-result gate re-armed by each trigger
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            resultTaken_ff <= 1'b1;
            swInPrev_ff    <= 2'b00;
        end else begin
            swInPrev_ff <= switchInPair;
            if (trigger)
                resultTaken_ff <= 1'b0;
            else if (fwdRead && txStart)
                resultTaken_ff <= 1'b1;
        end
    end

    // AHB address phase capture
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sel_ff <= 1'b0;
            wr_ff  <= 1'b0;
            ofs_ff <= 8'h00;
        end else if (hready) begin
            sel_ff <= acc;
            wr_ff  <= hwrite;
            ofs_ff <= aofs;
        end
    end

    // Register writes; event sets win over W1C clears
    wire [31:0] evt = {28'h0, trigger, fwdRead && txStart,
                       emitNow && !probeHit && txStart, state_ff == NMC_PROBE &&
                       searchEnd};
    wire [31:0] w1c = (wrData && ofs_ff == OFS_IRQ) ? hwdata : 32'h0;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_ff    <= CTRL_RST;
            hostCfg_ff <= HOSTCFG_RST;
            mask_ff    <= 32'h0000_0000;
            irq_ff     <= 32'h0000_0000;
            swLast_ff  <= 5'd0;
            swOut_ff   <= 32'h0000_0000;
            seqOk_ff   <= 1'b0;
        end else begin
            irq_ff <= (irq_ff & ~w1c) | evt;
            if (state_ff == NMC_RUN) seqOk_ff <= 1'b1;
            if (wrData) begin
                case (ofs_ff)
                    OFS_CTRL:    ctrl_ff    <= hwdata;
                    OFS_MASK:    mask_ff    <= hwdata;
                    OFS_SWLAST:  swLast_ff  <= hwdata[4:0];
                    OFS_SWOUT:   swOut_ff   <= hwdata;
                    OFS_HOSTCFG: hostCfg_ff <= hwdata;
                    default:     ;
                endcase
            end
        end
    end

    // Read mux
    logic [31:0] rdMux;
    always_comb begin
        case (aofs)
            OFS_CTRL:    rdMux = ctrl_ff;
            OFS_STATUS:  rdMux = {23'h0, seqOk_ff, 3'b000, lastAddr_ff};
            OFS_IRQ:     rdMux = irq_ff;
            OFS_MASK:    rdMux = mask_ff;
            OFS_SWLAST:  rdMux = {27'h0, swLast_ff};
            OFS_SWOUT:   rdMux = swOut_ff;
            OFS_HOSTCFG: rdMux = hostCfg_ff;
            OFS_ALIVE:   rdMux = alive_ff;
            default:     rdMux = 32'h0000_0000;
        endcase
    end

    // Registered outputs
    // A zero baud value falls back to the service rate, never divides
    wire [15:0] cfgDiv = serviceSelector ? 16'(SVC_DIV)
                         : 16'(CLK_HZ / {14'h0, hostCfg_ff[17:0]});
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hrdata_ff <= 32'h0000_0000;
            irq_o_ff  <= 1'b0;
            susp_ff   <= 1'b0;
            baud_ff   <= 16'h0000;
            swOutQ_ff <= 2'b00;
            lamp_ff   <= 2'b00;
        end else begin
            if (acc && !hwrite) hrdata_ff <= rdMux;
            irq_o_ff  <= |(irq_ff & mask_ff);
            susp_ff   <= serviceSelector;
            baud_ff   <= (hostCfg_ff[17:0] == 18'h0) ? 16'(SVC_DIV) : cfgDiv;
            swOutQ_ff <= SCANNER_VAR ? swOut_ff[1:0] : 2'b00;
            lamp_ff   <= SCANNER_VAR ? swOut_ff[1:0] : 2'b00;
        end
    end

    // Bus never stalls and always answers OKAY
    assign hrdata        = hrdata_ff;
    assign hreadyout     = 1'b1;
    assign hresp         = 1'b0;
    assign irq           = irq_o_ff;
    assign hostSuspended = susp_ff;
    assign baudDiv       = baud_ff;
    assign switchOut     = swOutQ_ff;
    assign lampOut       = lamp_ff;
endmodule : network_master_control
`default_nettype wire

// [bench/nmc_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module nmc_assertions
    import nmc_pkg::*;
#(
    parameter bit SCANNER_VAR = 1'b1
)(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        txRdy,
    input  wire logic        serviceSelector,
    input  wire logic        netTxVld,
    input  wire logic [7:0]  netTxByte,
    input  wire logic        hostTxVld,
    input  wire logic [7:0]  hostTxByte,
    input  wire logic        svcTxVld,
    input  wire logic [15:0] baudDiv,
    input  wire logic [1:0]  switchOut,
    input  wire logic [1:0]  lampOut,
    input  wire logic        hostSuspended
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [2:0] bytePos_ff;
    logic       live_ff;
    // Low until one edge outside reset; registered outputs lag reset by a cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) live_ff <= 1'b0;
        else live_ff <= 1'b1;
    end
    // Byte position in the frame, realigned by every reset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) bytePos_ff <= 3'h0;
        else if (netTxVld && txRdy) bytePos_ff <= (bytePos_ff == 3'h6) ? 3'h0 : bytePos_ff + 3'h1;
    end
    property p_lamp; lampOut == switchOut; endproperty
    a_lamp: assert property (p_lamp) else $error("lamp differs from output");
    property p_compact; !SCANNER_VAR |-> switchOut == 2'h0; endproperty
    a_compact: assert property (p_compact) else $error("compact output driven");
    property p_svcBaud;
        (live_ff && serviceSelector) ##1 serviceSelector |-> baudDiv == 16'(SVC_DIV);
    endproperty
    a_svcBaud: assert property (p_svcBaud) else $error("service baud wrong");
    property p_susp; (live_ff && serviceSelector) ##1 serviceSelector |-> hostSuspended; endproperty
    a_susp: assert property (p_susp) else $error("host not suspended");
    property p_quiet; serviceSelector[*2] |-> !hostTxVld; endproperty
    a_quiet: assert property (p_quiet) else $error("host sends in service");
    property p_route; hostTxVld |-> !svcTxVld && hostTxByte == netTxByte; endproperty
    a_route: assert property (p_route) else $error("host byte not frame byte");
    property p_hold; netTxVld && !txRdy |=> netTxVld && $stable(netTxByte); endproperty
    a_hold: assert property (p_hold) else $error("byte dropped while stalled");
    property p_stx; netTxVld && bytePos_ff == 3'h0 |-> netTxByte == CH_STX; endproperty
    a_stx: assert property (p_stx) else $error("frame not opened by start");
    property p_tail;
        netTxVld && bytePos_ff >= 3'h5 |-> netTxByte == ((bytePos_ff == 3'h5) ? CH_CR : CH_LF);
    endproperty
    a_tail: assert property (p_tail) else $error("frame end wrong");
    property p_digit;
        netTxVld && bytePos_ff inside {3'h1, 3'h2} |-> netTxByte inside {[8'h30:8'h39]};
    endproperty
    a_digit: assert property (p_digit) else $error("address not a digit");
    c_svc: cover property (svcTxVld);
    c_tout: cover property (hostTxVld && hostTxByte == CH_T);
    c_stall: cover property (netTxVld && !txRdy);
endmodule : nmc_assertions
`default_nettype wire

// [bench/nmc_slave_net.sv]
`timescale 1ns/1ps
`default_nettype none
module nmc_slave_net
    import nmc_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [31:0] aliveMask,
    input  wire logic [4:0]  lastAddr,
    input  wire logic        slowMode,
    input  wire logic        netTxVld,
    input  wire logic [7:0]  netTxByte,
    output logic             txRdy,
    output logic             slaveAnsVld,
    output logic [7:0]       slaveAnsAddr,
    output logic             slaveAnsIsRead,
    output logic [7:0]       slaveAnsData
);
    logic [4:0] frames_ff, poll_ff;
    logic [7:0] rdA, rdD;
    logic       rdPend;
    // Live slaves answer in turn until every address has been reported
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            {frames_ff, txRdy, slaveAnsVld, rdPend, slaveAnsIsRead, slaveAnsData} <= '0;
            poll_ff <= 5'h1;
        end else begin
            txRdy <= slowMode ? ~txRdy : 1'b1; // Slow mode drops ready every other cycle
            if (netTxVld && txRdy && netTxByte == CH_CR) frames_ff <= frames_ff + 5'h1;
            poll_ff <= (poll_ff >= lastAddr) ? 5'h1 : poll_ff + 5'h1;
            slaveAnsIsRead <= rdPend;
            slaveAnsVld <= rdPend || (frames_ff < lastAddr && aliveMask[poll_ff]);
            slaveAnsAddr <= rdPend ? rdA : {3'h0, poll_ff};
            slaveAnsData <= rdPend ? rdD : ~slaveAnsData; // Idle data never parks
            rdPend <= 1'b0;
        end
    end
    // One read result; set mid-cycle so the clearing edge cannot race it
    task automatic sendRead(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        rdA = a;
        rdD = d;
        rdPend = 1'b1;
        @(posedge clk_sys);
    endtask : sendRead
endmodule : nmc_slave_net
`default_nettype wire

// [bench/tb_network_master_control.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
    $display("FAIL t=%0t got %h exp %h", $time, a, b); end end
module tb_network_master_control import nmc_pkg::*;;
    logic        clk_sys = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready;
    logic        serviceSelector = 1'b0, hostRxVld = 1'b0, slowMode = 1'b1;
    logic [1:0]  htrans = 2'h0, switchInPair = 2'h0, switchOut, lampOut;
    logic [2:0]  hsize = 3'h2;
    logic [4:0]  rotarySel = 5'h03, netLast = 5'h03;
    logic [7:0]  hostRxByte = 8'h00, slaveAnsAddr, slaveAnsData, netTxByte, hostTxByte, svcTxByte;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, aliveMask = 32'h0000_000a, rd, hrdata;
    logic        hreadyout, hresp, irq, slaveAnsVld, slaveAnsIsRead, txRdy, netTxVld;
    logic        hostTxVld, svcTxVld, hostSuspended;
    logic [15:0] baudDiv;
    logic [7:0]  hostQ[$], svcQ[$];
    int          failures = 0, n_checks = 0, i;
    assign hready = hreadyout;
    always #12.5 clk_sys = ~clk_sys;
    // Bytes accepted on each serial port
    always @(posedge clk_sys) begin
        if (hostTxVld && txRdy) hostQ.push_back(hostTxByte);
        if (svcTxVld && txRdy) svcQ.push_back(svcTxByte);
    end
    network_master_control #(.INIT_CYC(2000), .PROBE_CYC(50)) DUT (.clk_sys, .rst, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .irq,
        .rotarySel, .serviceSelector, .switchInPair, .slaveAnsVld, .slaveAnsAddr,
        .slaveAnsIsRead, .slaveAnsData, .hostRxVld, .hostRxByte, .txRdy, .netTxVld, .netTxByte,
        .hostTxVld, .hostTxByte, .svcTxVld, .svcTxByte, .baudDiv, .switchOut, .lampOut,
        .hostSuspended);
    nmc_slave_net NET (.clk_sys, .rst, .aliveMask, .lastAddr(netLast), .slowMode, .netTxVld,
        .netTxByte, .txRdy, .slaveAnsVld, .slaveAnsAddr, .slaveAnsIsRead, .slaveAnsData);
    task automatic give_verdict;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    // Bounded wait for the bus to accept a phase
    task automatic waitRdy;
        int k;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (hreadyout !== 1'b1) begin failures++; give_verdict(); end
    endtask : waitRdy
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        waitRdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        waitRdy();
        rd = hrdata;
    endtask : bus
    task automatic waitBytes(input int n);
        int k;
        for (k = 0; k < 30000 && hostQ.size() + svcQ.size() < n; k++) @(posedge clk_sys);
        if (hostQ.size() + svcQ.size() < n) begin failures++; give_verdict(); end
    endtask : waitBytes
    // Pops one whole frame; address given in binary
    task automatic chkFrame(input logic svc, input logic [7:0] a, input logic [7:0] p0);
        logic [7:0] f [7];
        foreach (f[j]) f[j] = svc ? svcQ.pop_front() : hostQ.pop_front();
        `CHK(f[0], CH_STX)
        `CHK({f[1], f[2]}, {CH_ZERO + a / 8'h0a, CH_ZERO + a % 8'h0a})
        `CHK({f[3], f[5], f[6]}, {p0, CH_CR, CH_LF})
    endtask : chkFrame
    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        bus(0, OFS_CTRL, 32'h0);
        `CHK(rd, CTRL_RST)
        bus(0, OFS_HOSTCFG, 32'h0);
        `CHK(rd, HOSTCFG_RST)
        bus(0, 8'h40, 32'h0);
        `CHK(rd, 32'h0)
        rotarySel <= 5'h07; // Turned after power-up, must not count yet
        waitBytes(21);
        chkFrame(0, 8'h01, CH_S);
        chkFrame(0, 8'h02, CH_T);
        chkFrame(0, 8'h03, CH_S);
        i = 0;
        do begin
            bus(0, OFS_STATUS, 32'h0);
            i++;
        end while (rd[8] !== 1'b1 && i < 2000);
        `CHK(rd, 32'h0000_0103)
        bus(0, OFS_IRQ, 32'h0);
        `CHK(rd[1:0], 2'h3)
        bus(1, OFS_MASK, 32'h2);
        repeat (2) @(posedge clk_sys);
        `CHK(irq, 1'b1)
        bus(1, OFS_IRQ, 32'h2);
        repeat (2) @(posedge clk_sys);
        `CHK(irq, 1'b0)
        bus(1, OFS_SWOUT, 32'h2);
        bus(1, OFS_HOSTCFG, 32'h0000_4b00);
        repeat (2) @(posedge clk_sys);
        `CHK({switchOut, lampOut}, 4'ha)
        `CHK(baudDiv, 16'(CLK_HZ / 19200))
        slowMode <= 1'b0;
        for (i = 0; i < 2; i++) begin
            bus(1, OFS_CTRL, {29'h0, i[0], 2'h0});
            NET.sendRead(8'h03, 8'h43 + 8'(i));
            waitBytes(7);
            chkFrame(0, i[0] ? 8'h00 : 8'h03, 8'h43 + 8'(i));
        end
        bus(1, OFS_CTRL, 32'h5);
        bus(1, OFS_IRQ, 32'hf);
        hostRxByte <= CH_PLUS;
        hostRxVld <= 1'b1;
        @(posedge clk_sys);
        hostRxVld <= 1'b0;
        NET.sendRead(8'h03, 8'h41);
        repeat (20) @(posedge clk_sys); // Sender idle again, only the gate may drop it
        NET.sendRead(8'h01, 8'h42);
        repeat (300) @(posedge clk_sys);
        `CHK(hostQ.size(), 7)
        chkFrame(0, 8'h00, 8'h41);
        bus(0, OFS_IRQ, 32'h0);
        `CHK(rd[3:2], 2'h3)
        bus(1, OFS_IRQ, 32'hf);
        switchInPair <= 2'h1;
        repeat (4) @(posedge clk_sys);
        bus(0, OFS_IRQ, 32'h0);
        `CHK(rd[3], 1'b1)
        serviceSelector <= 1'b1;
        rotarySel <= 5'h04;
        netLast <= 5'h04;
        aliveMask <= 32'h0000_001e;
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        hostQ.delete();
        svcQ.delete();
        rst <= 1'b0;
        waitBytes(28);
        `CHK({hostQ.size(), baudDiv, hostSuspended}, {32'h0, 16'(SVC_DIV), 1'b1})
        for (i = 1; i < 5; i++) chkFrame(1, 8'(i), CH_S);
        give_verdict();
    end
endmodule : tb_network_master_control
bind network_master_control nmc_assertions #(.SCANNER_VAR(SCANNER_VAR)) u_chk (.clk_sys,
    .rst, .txRdy, .serviceSelector, .netTxVld, .netTxByte, .hostTxVld, .hostTxByte,
    .svcTxVld, .baudDiv, .switchOut, .lampOut, .hostSuspended);
`default_nettype wire
